/* hdl/dbg_trigger_cfg.svh */
// register offsets, field positions, reset values and mode codes of the trigger block
`ifndef DBG_TRIGGER_CFG_SVH
`define DBG_TRIGGER_CFG_SVH

// ==========================================================
// register offsets (word index on the plain register port)
`define REG_COMP_A 3'h0
`define REG_COMP_B 3'h1
`define REG_TRIG_CTL 3'h2
`define REG_DBG_CTL 3'h3
`define REG_DBG_STAT 3'h4
`define REG_FIFO_DATA 3'h5

// ==========================================================
// trigger_control_reg fields
`define TRG_MODE_LSB 0
`define TRG_MODE_MSB 3
`define TRG_BEGIN_BIT 6
`define TRG_TYPE_SEL_BIT 7

// ==========================================================
// debug_control_reg fields
`define CTL_RWB_BIT 0
`define CTL_COMP_B_RW_QUALIFY_EN_BIT 1
`define CTL_RWA_BIT 2
`define CTL_COMP_A_RW_QUALIFY_EN_BIT 3
`define CTL_BRK_BIT 4
`define CTL_TAG_BIT 5
`define CTL_ARM_BIT 6
`define CTL_EN_BIT 7

// ==========================================================
// debug_status_reg fields
`define STAT_CNT_LSB 0
`define STAT_CNT_MSB 3
`define STAT_BF_BIT 5
`define STAT_AF_BIT 6
`define STAT_ARMED_FLAG_BIT 7

// ==========================================================
// reset values
`define RST_COMP 16'h0000
`define RST_MODE 4'h0

// ==========================================================
// trigger_mode_field codes
`define MODE_A_ONLY 4'h0
`define MODE_A_OR_B 4'h1
`define MODE_A_THEN_B 4'h2
`define MODE_EVENT_B 4'h3
`define MODE_A_THEN_EVENT_B 4'h4
`define MODE_A_AND_B_DATA 4'h5
`define MODE_A_AND_NOT_B_DATA 4'h6
`define MODE_INSIDE 4'h7
`define MODE_OUTSIDE 4'h8

`endif

/* hdl/dbg_trigger_pkg.sv */
// types shared by the trigger and breakpoint block
package dbg_trigger_pkg;

  // ==========================================================
  // decoded trigger modes
  typedef enum logic [3:0] {
    mode_none,
    mode_a_only,
    mode_a_or_b,
    mode_a_then_b,
    mode_event_b,
    mode_a_then_event_b,
    mode_a_and_b_data,
    mode_a_and_not_b_data,
    mode_inside,
    mode_outside
  } mode_type;

  // ==========================================================
  // debug run states
  typedef enum logic [1:0] {
    run_idle,
    run_wait,
    run_begin,
    run_end
  } run_type;

endpackage

/* hdl/opcode_tracker.sv */
// follows one matched opcode through the instruction queue until executed or discarded
`timescale 1ns/1ns
module opcode_tracker #(
  parameter int AW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fetch_match,
  input wire logic [AW-1:0] fetch_addr,
  input wire logic exec_valid,
  input wire logic [AW-1:0] exec_addr,
  input wire logic flush,
  output logic executed
);

  // ==========================================================
  // state
  typedef struct packed {
    logic pending;
    logic [AW-1:0] addr;
    logic executed;
  } track_state_type;

  track_state_type q;
  track_state_type d;

  // ==========================================================
  // tracking
  // one pending opcode per comparator; a newer match replaces an older one
  always_comb begin
    d = q;
    d.executed = 1'b0;
    if (q.pending && exec_valid && exec_addr == q.addr) begin
      d.executed = 1'b1;
      d.pending = 1'b0;
    end
    // discarded opcodes vanish without any action
    if (flush) begin
      d.pending = 1'b0;
    end
    // a new fetch match wins over the flush of the same cycle
    if (fetch_match) begin
      d.pending = 1'b1;
      d.addr = fetch_addr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign executed = q.executed;

endmodule

/* hdl/dbg_trigger.sv */
// debug trigger, trace capture and cpu breakpoint logic
//
// Function
// - tag request marks the matched opcode entering the queue; discarded ones do nothing
// - force request lets the current instruction finish, then background entry
// - outside the range modes, tag-type triggers count a match only once its opcode executes
// - comparators A and B each own an independent opcode tracker
// - four-bit mode field in trigger control picks one of nine modes
// - begin select starts storing at trigger; end trace stores circularly until it
// - writing arm and enable both as one sets armed, clears both match flags and count
// - begin run ends when fifo fills; end run ends at trigger
// - writing zero to arm or enable stops any run at once
// - fifo keeps change-of-flow addresses, or data bytes in event-only modes
// - event-only modes ignore begin select and always run as begin traces
// - each comparator may require read/write to equal its chosen value
// - with break enable the trigger raises a tag or force cpu request
// - A-only triggers on A match; A-or-B on either match
// - A-then-B triggers on B match any time after an A match
// - full and mode needs A address, B low byte data, rw check together
// - full not mode needs A address, data unlike B low byte, rw check
// - tag break in full modes ignores data and fires on A address match
// - event-only B captures data on each B match until fifo full
// - A-then-event-B captures data on B matches after A, until full
// - inside range is A to B inclusive; outside is below A or above B
// - without background permit the cpu takes a software interrupt instead
// - full modes compare write data if A qualifies on writes, else read data
// - background controller accesses never produce comparator matches
`timescale 1ns/1ns
`include "dbg_trigger_cfg.svh"
module dbg_trigger #(
  parameter int DEPTH = 8,
  parameter logic [7:0] BACKGROUND_ENTRY_OPCODE = 8'h00,
  parameter logic [7:0] SOFTWARE_INTERRUPT_OPCODE = 8'h01
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic bus_cycle,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_read,
  input wire logic [7:0] cpu_read_data,
  input wire logic [7:0] cpu_write_data,
  input wire logic bdc_access,
  input wire logic opcode_fetch,
  input wire logic exec_valid,
  input wire logic [15:0] exec_addr,
  input wire logic queue_flush,
  input wire logic cof_valid,
  input wire logic [15:0] cof_addr,
  input wire logic background_mode_permit,
  output logic tag_request,
  output logic force_request,
  output logic [7:0] substitute_opcode,
  output logic break_to_swi
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  // ==========================================================
  // parameter check
  // the count must fit the four-bit status field
  if (DEPTH < 2 || DEPTH > 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("dbg_trigger: DEPTH must be 2, 4 or 8");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0] comp_a;
    logic [15:0] comp_b;
    logic [3:0] mode;
    logic begin_sel;
    logic type_sel;
    logic enable;
    logic tag_sel;
    logic brk_en;
    logic rwa_en;
    logic comp_a_rw_value;
    logic rwb_en;
    logic comp_b_rw_value;
    dbg_trigger_pkg::run_type run;
    logic af;
    logic bf;
    logic [DEPTH-1:0][15:0] mem;
    logic [PW-1:0] wr;
    logic [CW-1:0] count;
    logic [15:0] rdata;
    logic tag_req;
    logic force_req;
    logic [7:0] sub_op;
    logic software_interrupt_opcode;
  } state_type;

  state_type q;
  state_type d;

  // ==========================================================
  // helper functions
  function automatic dbg_trigger_pkg::mode_type decode_mode(input logic [3:0] code);
    dbg_trigger_pkg::mode_type m;
    m = dbg_trigger_pkg::mode_none;
    case (code)
      `MODE_A_ONLY: m = dbg_trigger_pkg::mode_a_only;
      `MODE_A_OR_B: m = dbg_trigger_pkg::mode_a_or_b;
      `MODE_A_THEN_B: m = dbg_trigger_pkg::mode_a_then_b;
      `MODE_EVENT_B: m = dbg_trigger_pkg::mode_event_b;
      `MODE_A_THEN_EVENT_B: m = dbg_trigger_pkg::mode_a_then_event_b;
      `MODE_A_AND_B_DATA: m = dbg_trigger_pkg::mode_a_and_b_data;
      `MODE_A_AND_NOT_B_DATA: m = dbg_trigger_pkg::mode_a_and_not_b_data;
      `MODE_INSIDE: m = dbg_trigger_pkg::mode_inside;
      `MODE_OUTSIDE: m = dbg_trigger_pkg::mode_outside;
      default: m = dbg_trigger_pkg::mode_none;
    endcase
    return m;
  endfunction

  function automatic logic is_event(input dbg_trigger_pkg::mode_type m);
    return m == dbg_trigger_pkg::mode_event_b || m == dbg_trigger_pkg::mode_a_then_event_b;
  endfunction

  function automatic logic is_full(input dbg_trigger_pkg::mode_type m);
    return m == dbg_trigger_pkg::mode_a_and_b_data || m == dbg_trigger_pkg::mode_a_and_not_b_data;
  endfunction

  // evaluated on the type-selected hits, and again on raw fetch hits for tagging outside the full modes
  function automatic logic trig_eval(input dbg_trigger_pkg::mode_type m, input logic a,
                                     input logic b, input logic a_seen, input logic dmatch,
                                     input logic in_rng, input logic cyc);
    logic t;
    t = 1'b0;
    case (m)
      dbg_trigger_pkg::mode_a_only: t = a;
      dbg_trigger_pkg::mode_a_or_b: t = a | b;
      dbg_trigger_pkg::mode_a_then_b: t = b & a_seen;
      dbg_trigger_pkg::mode_event_b: t = b;
      dbg_trigger_pkg::mode_a_then_event_b: t = b & a_seen;
      dbg_trigger_pkg::mode_a_and_b_data: t = a & dmatch;
      dbg_trigger_pkg::mode_a_and_not_b_data: t = a & ~dmatch;
      dbg_trigger_pkg::mode_inside: t = cyc & in_rng;
      dbg_trigger_pkg::mode_outside: t = cyc & ~in_rng;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // ==========================================================
  // comparators
  dbg_trigger_pkg::mode_type mode;
  logic cyc;
  logic qual_a;
  logic qual_b;
  logic raw_a;
  logic raw_b;
  logic trk_a;
  logic trk_b;
  logic hit_a;
  logic hit_b;
  logic [7:0] cmp_data;
  logic dmatch;
  logic in_rng;
  logic trig;
  logic tag_trig;

  always_comb begin
    mode = decode_mode(q.mode);
    cyc = bus_cycle & ~bdc_access;
    qual_a = ~q.rwa_en | (cpu_read == q.comp_a_rw_value);
    qual_b = ~q.rwb_en | (cpu_read == q.comp_b_rw_value);
    raw_a = cyc & qual_a & (cpu_addr == q.comp_a);
    raw_b = cyc & qual_b & (cpu_addr == q.comp_b);
    // rwa low means write cycles are selected
    cmp_data = (q.rwa_en && !q.comp_a_rw_value) ? cpu_write_data : cpu_read_data;
    dmatch = cmp_data == q.comp_b[7:0];
    in_rng = cpu_addr >= q.comp_a && cpu_addr <= q.comp_b;
    hit_a = q.type_sel ? trk_a : raw_a;
    hit_b = q.type_sel ? trk_b : raw_b;
    trig = trig_eval(mode, hit_a, hit_b, q.af, dmatch, in_rng, cyc & qual_a);
    // tagging needs the raw match on the fetch itself, before execution
    if (is_full(mode)) begin
      tag_trig = raw_a;
    end else begin
      tag_trig = trig_eval(mode, raw_a, raw_b, q.af, dmatch, in_rng, cyc & qual_a);
    end
    tag_trig = tag_trig & opcode_fetch;
  end

  // ==========================================================
  // opcode trackers, one per comparator
  opcode_tracker #(
    .AW(16)
  ) u_track_a (
    .clk(clk),
    .rst_n(rst_n),
    .fetch_match(raw_a & opcode_fetch),
    .fetch_addr(cpu_addr),
    .exec_valid(exec_valid),
    .exec_addr(exec_addr),
    .flush(queue_flush),
    .executed(trk_a)
  );

  opcode_tracker #(
    .AW(16)
  ) u_track_b (
    .clk(clk),
    .rst_n(rst_n),
    .fetch_match(raw_b & opcode_fetch),
    .fetch_addr(cpu_addr),
    .exec_valid(exec_valid),
    .exec_addr(exec_addr),
    .flush(queue_flush),
    .executed(trk_b)
  );

  // ==========================================================
  // run control, fifo and registers
  logic push;
  logic [15:0] push_word;
  logic armed;
  logic [PW-1:0] oldest;

  always_comb begin
    d = q;
    d.tag_req = 1'b0;
    d.force_req = 1'b0;
    d.rdata = 16'h0000;
    push = 1'b0;
    push_word = cof_addr;
    armed = q.run != dbg_trigger_pkg::run_idle;
    oldest = PW'(q.wr - q.count[PW-1:0]);

    // run progression
    case (q.run)
      dbg_trigger_pkg::run_wait: begin
        if (is_event(mode)) begin
          // event-only: every trigger stores one data byte
          push = trig;
          push_word = {8'h00, cpu_read ? cpu_read_data : cpu_write_data};
        end else if (trig) begin
          d.run = dbg_trigger_pkg::run_begin;
        end
      end
      dbg_trigger_pkg::run_begin: begin
        push = cof_valid;
      end
      dbg_trigger_pkg::run_end: begin
        push = cof_valid;
        if (trig) begin
          d.run = dbg_trigger_pkg::run_idle;
        end
      end
      default: begin
        push = 1'b0;
      end
    endcase

    if (push) begin
      d.mem[q.wr] = push_word;
      d.wr = PW'(q.wr + 1'b1);
      if (q.count != CW'(DEPTH)) begin
        d.count = CW'(q.count + 1'b1);
      end
      // begin-type runs stop on the word that fills the fifo
      if (q.run != dbg_trigger_pkg::run_end && q.count == CW'(DEPTH - 1)) begin
        d.run = dbg_trigger_pkg::run_idle;
      end
    end

    // readout pops the oldest word, only while no run is active
    if (reg_rd && reg_addr == `REG_FIFO_DATA && !armed && q.count != '0) begin
      d.count = CW'(q.count - 1'b1);
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `REG_COMP_A: d.comp_a = reg_wdata;
        `REG_COMP_B: d.comp_b = reg_wdata;
        `REG_TRIG_CTL: begin
          d.mode = reg_wdata[`TRG_MODE_MSB:`TRG_MODE_LSB];
          d.begin_sel = reg_wdata[`TRG_BEGIN_BIT];
          d.type_sel = reg_wdata[`TRG_TYPE_SEL_BIT];
        end
        `REG_DBG_CTL: begin
          d.enable = reg_wdata[`CTL_EN_BIT];
          d.tag_sel = reg_wdata[`CTL_TAG_BIT];
          d.brk_en = reg_wdata[`CTL_BRK_BIT];
          d.rwa_en = reg_wdata[`CTL_COMP_A_RW_QUALIFY_EN_BIT];
          d.comp_a_rw_value = reg_wdata[`CTL_RWA_BIT];
          d.rwb_en = reg_wdata[`CTL_COMP_B_RW_QUALIFY_EN_BIT];
          d.comp_b_rw_value = reg_wdata[`CTL_RWB_BIT];
          if (!reg_wdata[`CTL_ARM_BIT] || !reg_wdata[`CTL_EN_BIT]) begin
            d.run = dbg_trigger_pkg::run_idle;
          end else begin
            d.af = 1'b0;
            d.bf = 1'b0;
            d.count = '0;
            d.wr = '0;
            // event-only runs never use the end-trace form
            if (q.begin_sel || is_event(mode)) begin
              d.run = dbg_trigger_pkg::run_wait;
            end else begin
              d.run = dbg_trigger_pkg::run_end;
            end
          end
        end
        default: d.comp_a = d.comp_a;
      endcase
    end

    // match flags: a hit in the clearing cycle still sets when re-arming a run already armed
    if (armed && hit_a) begin
      d.af = 1'b1;
    end
    if (armed && hit_b) begin
      d.bf = 1'b1;
    end

    // cpu breakpoint requests
    if (armed && q.enable && q.brk_en) begin
      d.tag_req = q.tag_sel & tag_trig;
      d.force_req = ~q.tag_sel & trig;
    end
    d.software_interrupt_opcode = ~background_mode_permit;
    d.sub_op = background_mode_permit ? BACKGROUND_ENTRY_OPCODE
                                      : SOFTWARE_INTERRUPT_OPCODE;

    // read data, valid only in the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `REG_COMP_A: d.rdata = q.comp_a;
        `REG_COMP_B: d.rdata = q.comp_b;
        `REG_TRIG_CTL: begin
          d.rdata[`TRG_MODE_MSB:`TRG_MODE_LSB] = q.mode;
          d.rdata[`TRG_BEGIN_BIT] = q.begin_sel;
          d.rdata[`TRG_TYPE_SEL_BIT] = q.type_sel;
        end
        `REG_DBG_CTL: begin
          d.rdata[`CTL_EN_BIT] = q.enable;
          d.rdata[`CTL_ARM_BIT] = armed;
          d.rdata[`CTL_TAG_BIT] = q.tag_sel;
          d.rdata[`CTL_BRK_BIT] = q.brk_en;
          d.rdata[`CTL_COMP_A_RW_QUALIFY_EN_BIT] = q.rwa_en;
          d.rdata[`CTL_RWA_BIT] = q.comp_a_rw_value;
          d.rdata[`CTL_COMP_B_RW_QUALIFY_EN_BIT] = q.rwb_en;
          d.rdata[`CTL_RWB_BIT] = q.comp_b_rw_value;
        end
        `REG_DBG_STAT: begin
          d.rdata[`STAT_ARMED_FLAG_BIT] = armed;
          d.rdata[`STAT_AF_BIT] = q.af;
          d.rdata[`STAT_BF_BIT] = q.bf;
          d.rdata[`STAT_CNT_MSB:`STAT_CNT_LSB] = 4'(q.count);
        end
        `REG_FIFO_DATA: d.rdata = q.mem[oldest];
        default: d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.comp_a <= `RST_COMP;
      q.comp_b <= `RST_COMP;
      q.mode <= `RST_MODE;
      q.run <= dbg_trigger_pkg::run_idle;
      q.software_interrupt_opcode <= 1'b1;
      q.sub_op <= SOFTWARE_INTERRUPT_OPCODE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata = q.rdata;
  assign tag_request = q.tag_req;
  assign force_request = q.force_req;
  assign substitute_opcode = q.sub_op;
  assign break_to_swi = q.software_interrupt_opcode;

endmodule

/* test/trig_sva.sv */
// port assertions for the trigger and breakpoint block
`timescale 1ns/1ns
module trig_sva #(
  parameter logic [7:0] BGE = 8'h00,
  parameter logic [7:0] SWIO = 8'h01
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic bus_cycle,
  input wire logic opcode_fetch,
  input wire logic bdc_access,
  input wire logic exec_valid,
  input wire logic background_mode_permit,
  input wire logic tag_request,
  input wire logic force_request,
  input wire logic [7:0] substitute_opcode,
  input wire logic break_to_swi
);
  // ====================
  // relations between ports
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray read data");
  rd_unmapped_a:
    assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
  tag_cause_a:
    assert property (tag_request |-> $past(bus_cycle && opcode_fetch && !bdc_access))
      else $error("tag request without opcode fetch");
  force_cause_a:
    assert property (force_request |-> $past(bus_cycle && !bdc_access) || $past(exec_valid, 2))
      else $error("force request without cause");
  req_kind_a:
    assert property (!(tag_request && force_request)) else $error("tag and force together");
  tag_pulse_a:
    assert property (tag_request |=> !tag_request) else $error("tag request too long");
  swi_follow_a:
    assert property ($past(rst_n) |-> break_to_swi == !$past(background_mode_permit))
      else $error("swi select not following permit");
  subst_op_a:
    assert property (substitute_opcode == (break_to_swi ? SWIO : BGE))
      else $error("wrong substitute opcode");
endmodule

bind dbg_trigger trig_sva #(.BGE(BACKGROUND_ENTRY_OPCODE), .SWIO(SOFTWARE_INTERRUPT_OPCODE))
  chk_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .bus_cycle(bus_cycle), .opcode_fetch(opcode_fetch),
  .bdc_access(bdc_access), .exec_valid(exec_valid),
  .background_mode_permit(background_mode_permit), .tag_request(tag_request),
  .force_request(force_request), .substitute_opcode(substitute_opcode),
  .break_to_swi(break_to_swi));

/* test/queue_model.sv */
// instruction queue model: fetched opcodes execute four cycles on unless flushed
`timescale 1ns/1ns
module queue_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_cycle,
  input wire logic opcode_fetch,
  input wire logic [15:0] cpu_addr,
  input wire logic flush_cmd,
  output logic exec_valid,
  output logic [15:0] exec_addr,
  output logic queue_flush
);
  logic [2:0] vld_q;
  logic [15:0] adr_q [3];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vld_q <= 3'b000;
      exec_valid <= 1'b0;
      exec_addr <= 16'h0000;
      queue_flush <= 1'b0;
    end else begin
      queue_flush <= flush_cmd;
      // a flush throws queued opcodes away unexecuted
      vld_q <= flush_cmd ? 3'b000 : {vld_q[1:0], bus_cycle & opcode_fetch};
      adr_q[0] <= cpu_addr;
      adr_q[1] <= adr_q[0];
      adr_q[2] <= adr_q[1];
      exec_valid <= vld_q[2] & ~flush_cmd;
      // idle address toggles so a stale value never matches by luck
      exec_addr <= vld_q[2] ? adr_q[2] : ~exec_addr;
    end
  end
endmodule

/* test/tb.sv */
// self-checking bench for the trigger and breakpoint block
`timescale 1ns/1ns
`include "dbg_trigger_cfg.svh"
module tb;
  localparam logic [7:0] BGE = 8'h5a; // arbitrary
  localparam logic [7:0] SWIO = 8'ha5; // arbitrary
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, bus_cycle = 0, cpu_read = 1;
  logic bdc_access = 0, opcode_fetch = 0, cof_valid = 0, permit = 0, flush_cmd = 0;
  logic [2:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, cpu_addr = 0, cof_addr = 0, reg_rdata, exec_addr;
  logic [7:0] cpu_read_data = 0, cpu_write_data = 0, substitute_opcode;
  logic exec_valid, queue_flush, tag_request, force_request, break_to_swi;
  int err_total = 0, n_checks = 0, nforce = 0, ntag = 0, f0 = 0, t0 = 0, cyc = 0;

  // ====================
  // design and queue partner
  dbg_trigger #(.DEPTH(8), .BACKGROUND_ENTRY_OPCODE(BGE), .SOFTWARE_INTERRUPT_OPCODE(SWIO)) dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_cycle(bus_cycle), .cpu_addr(cpu_addr),
    .cpu_read(cpu_read), .cpu_read_data(cpu_read_data), .cpu_write_data(cpu_write_data),
    .bdc_access(bdc_access), .opcode_fetch(opcode_fetch), .exec_valid(exec_valid),
    .exec_addr(exec_addr), .queue_flush(queue_flush), .cof_valid(cof_valid),
    .cof_addr(cof_addr), .background_mode_permit(permit), .tag_request(tag_request),
    .force_request(force_request), .substitute_opcode(substitute_opcode),
    .break_to_swi(break_to_swi));
  queue_model qm (.clk(clk), .rst_n(rst_n), .bus_cycle(bus_cycle),
    .opcode_fetch(opcode_fetch), .cpu_addr(cpu_addr), .flush_cmd(flush_cmd),
    .exec_valid(exec_valid), .exec_addr(exec_addr), .queue_flush(queue_flush));

  // ====================
  // clock, pulse counters, hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (force_request === 1'b1) nforce++;
    if (tag_request === 1'b1) ntag++;
    if (cyc == 6000) begin
      err_total++;
      complete_run();
    end
  end

  // ====================
  // helpers
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic bus(input logic [15:0] ad, input logic rdn, input logic [7:0] rdt, wdt,
                     input logic f, input logic bd);
    @(posedge clk);
    bus_cycle <= 1'b1;
    cpu_addr <= ad;
    cpu_read <= rdn;
    cpu_read_data <= rdt;
    cpu_write_data <= wdt;
    opcode_fetch <= f;
    bdc_access <= bd;
    @(posedge clk);
    bus_cycle <= 1'b0;
    opcode_fetch <= 1'b0;
    bdc_access <= 1'b0;
    cpu_read_data <= ~rdt;
    cpu_write_data <= ~wdt;
  endtask
  task automatic pulse1();
    @(posedge clk);
    flush_cmd <= 1'b1;
    @(posedge clk);
    flush_cmd <= 1'b0;
  endtask
  task automatic setup(input logic [15:0] tc, ctl, a, b);
    wr(`REG_COMP_A, a);
    wr(`REG_COMP_B, b);
    wr(`REG_TRIG_CTL, tc);
    wr(`REG_DBG_CTL, ctl);
    f0 = nforce;
    t0 = ntag;
  endtask
  task automatic pulses(input int ef, input int et);
    repeat (8) @(posedge clk);
    #1;
    chk(16'(nforce - f0), 16'(ef));
    chk(16'(ntag - t0), 16'(et));
    f0 = nforce;
    t0 = ntag;
  endtask
  function automatic bit exp_trig(input logic [3:0] m, input logic [15:0] a, b, ad,
                                  input logic [7:0] d);
    case (m)
      `MODE_A_ONLY: return ad == a;
      `MODE_A_OR_B: return ad == a || ad == b;
      `MODE_A_AND_B_DATA: return ad == a && d == b[7:0];
      `MODE_A_AND_NOT_B_DATA: return ad == a && d != b[7:0];
      `MODE_INSIDE: return ad >= a && ad <= b;
      `MODE_OUTSIDE: return ad < a || ad > b;
      default: return 1'b0;
    endcase
  endfunction

  // ====================
  // scenarios
  initial begin
    logic [3:0] m;
    logic [15:0] a, b, ad;
    logic [7:0] dt;
    logic [15:0] q [8];
    void'($urandom(15322));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      m = 4'($urandom % 16);
      if (m inside {4'h2, 4'h3, 4'h4}) m = m + 4'h7;
      a = 16'($urandom);
      b = a + 16'($urandom % 8);
      case ($urandom % 4)
        0: ad = a;
        1: ad = b;
        2: ad = a + 16'h0001;
        default: ad = 16'($urandom);
      endcase
      dt = ($urandom % 2) ? b[7:0] : 8'($urandom);
      setup({12'h004, m}, 16'h00d0, a, b);
      bus(ad, 1'b1, dt, ~dt, 1'b0, 1'b0);
      pulses(int'(exp_trig(m, a, b, ad, dt)), 0);
    end
    setup(16'h0042, 16'h00d0, 16'h1000, 16'h2000);
    bus(16'h2000, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0);
    bus(16'h1000, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0);
    pulses(0, 0);
    bus(16'h2000, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0);
    pulses(1, 0);
    setup(16'h0040, 16'h00d8, 16'h3000, 16'h0000);
    bus(16'h3000, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0);
    pulses(0, 0);
    bus(16'h3000, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
    pulses(1, 0);
    setup(16'h0045, 16'h00d8, 16'h3000, 16'h00a5);
    bus(16'h3000, 1'b0, 8'h5a, 8'ha5, 1'b0, 1'b0);
    pulses(1, 0);
    bus(16'h3000, 1'b0, 8'ha5, 8'h5a, 1'b0, 1'b0);
    pulses(0, 0);
    setup(16'h0040, 16'h00d0, 16'h1234, 16'h0000);
    bus(16'h1234, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1);
    pulses(0, 0);
    bus(16'h1234, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0);
    pulses(1, 0);
    rdchk(`REG_DBG_STAT, 16'h00c0);
    wr(`REG_DBG_CTL, 16'h00d0);
    rdchk(`REG_DBG_STAT, 16'h0080);
    wr(`REG_DBG_CTL, 16'h0090);
    rdchk(`REG_DBG_STAT, 16'h0000);
    bus(16'h1234, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0);
    pulses(0, 0);
    setup(16'h0003, 16'h00c0, 16'hffff, 16'h0040);
    for (int i = 0; i < 8; i++) begin
      q[i] = {8'h00, 8'($urandom)};
      bus(16'h0040, 1'b1, q[i][7:0], 8'h00, 1'b0, 1'b0);
    end
    rdchk(`REG_DBG_STAT, 16'h0028);
    for (int i = 0; i < 8; i++) rdchk(`REG_FIFO_DATA, q[i]);
    setup(16'h0000, 16'h00c0, 16'h1234, 16'hffff);
    for (int i = 0; i < 3; i++) begin
      q[i] = 16'($urandom);
      @(posedge clk);
      cof_valid <= 1'b1;
      cof_addr <= q[i];
      @(posedge clk);
      cof_valid <= 1'b0;
      cof_addr <= ~q[i];
    end
    bus(16'h1234, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0);
    rdchk(`REG_DBG_STAT, 16'h0043);
    for (int i = 0; i < 3; i++) rdchk(`REG_FIFO_DATA, q[i]);
    setup(16'h0004, 16'h00c0, 16'h1000, 16'h0040);
    bus(16'h0040, 1'b1, 8'h11, 8'h00, 1'b0, 1'b0);
    bus(16'h1000, 1'b1, 8'h22, 8'h00, 1'b0, 1'b0);
    bus(16'h0040, 1'b1, 8'h33, 8'h00, 1'b0, 1'b0);
    rdchk(`REG_DBG_STAT, 16'h00e1);
    wr(`REG_DBG_CTL, 16'h0080);
    rdchk(`REG_FIFO_DATA, 16'h0033);
    rdchk(3'h7, 16'h0000);
    setup(16'h0040, 16'h00f0, 16'h4000, 16'h0000);
    bus(16'h4000, 1'b1, 8'h00, 8'h00, 1'b1, 1'b0);
    pulses(0, 1);
    setup(16'h0045, 16'h00f0, 16'h4000, 16'h0077);
    bus(16'h4000, 1'b1, 8'h00, 8'h00, 1'b1, 1'b0);
    pulses(0, 1);
    setup(16'h00c0, 16'h00d0, 16'h4000, 16'h0000);
    bus(16'h4000, 1'b1, 8'h00, 8'h00, 1'b1, 1'b0);
    pulses(1, 0);
    bus(16'h4000, 1'b1, 8'h00, 8'h00, 1'b1, 1'b0);
    pulse1();
    pulses(0, 0);
    setup(16'h00c1, 16'h00d0, 16'h4000, 16'h4002);
    bus(16'h4000, 1'b1, 8'h00, 8'h00, 1'b1, 1'b0);
    bus(16'h4002, 1'b1, 8'h00, 8'h00, 1'b1, 1'b0);
    pulses(2, 0);
    chk({8'h00, substitute_opcode}, {8'h00, SWIO});
    @(posedge clk);
    permit <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, break_to_swi}, 16'h0000);
    chk({8'h00, substitute_opcode}, {8'h00, BGE});
    complete_run();
  end
endmodule
